// ---- inc/dss_params.svh ----
// register offsets, field positions, reset values and widths of the dsp socket
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses on apb)
// ****************************************************************
`define DSS_OFF_CTRL      8'h00
`define DSS_OFF_SRC_LIMIT 8'h04
`define DSS_OFF_SNK_LIMIT 8'h08
`define DSS_OFF_IRQ_STAT  8'h0c
`define DSS_OFF_IRQ_MASK  8'h10
`define DSS_OFF_SNK_COUNT 8'h14
`define DSS_OFF_SRAM_STAT 8'h18
`define DSS_OFF_BUF_DATA  8'h1c
`define DSS_OFF_STEP_LSW  8'h20
`define DSS_OFF_STEP_MSW  8'h24
`define DSS_OFF_SNK_LSW   8'h28
`define DSS_OFF_SNK_MSW   8'h2c

// ****************************************************************
// field positions
// ****************************************************************
`define DSS_CTRL_START    0
`define DSS_CTRL_CONT     1
`define DSS_CTRL_CLEAR    2
`define DSS_CTRL_SNK_EN   3
`define DSS_CTRL_STEP     4
`define DSS_IRQ_LO        24
`define DSS_IRQ_HI        31
`define DSS_IRQ_SRC_DONE  0
`define DSS_IRQ_SNK_LIMIT 1
`define DSS_SRAM_CAL      0
`define DSS_SRAM_READY    1

// ****************************************************************
// reset values and widths
// ****************************************************************
`define DSS_SNK_EN_RESET  1'b1
`define DSS_DEF_WORD_W    32
`define DSS_CNT_W         16
`define DSS_SRAM_DATA_W   64
`define DSS_SRAM_ADDR_W   18
`define DSS_SRAM_LANE_W   8
`define DSS_DEF_BUF_DEPTH 16
`define DSS_DEF_BUF_AW    4
`define DSS_DEF_PADDR_W   12

`endif

// ---- inc/dss_pkg.sv ----
// types shared by the dsp socket design files
`default_nettype none
package dss_pkg;
  typedef logic [31:0] dss_word_t;
  typedef enum logic [2:0] {
    DSS_SRC_IDLE = 3'b001,
    DSS_SRC_RUN  = 3'b010,
    DSS_SRC_STEP = 3'b100
  } dss_src_state_t;
endpackage
`default_nettype wire

// ---- rtl/dss_word_ram.sv ----
// source word buffer: one write port, one registered read port
`default_nettype none
module dss_word_ram #(
  parameter int W     = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [W-1:0]  rd_data
);
  import dss_pkg::*;

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dss_socket.sv ----
// dsp socket: stream source and sink ports, interrupts, sram user port, apb registers
//
// Added by the designer: the APB slave port and the placing of the registers.
`include "dss_params.svh"
`default_nettype none

// Functional notes
// [R1] after accept drops, source valid may stay high at most two more cycles; a single step raises valid for one cycle regardless of accept
// [R2] user logic should buffer source words and drive accept from not-full
// [R3] source and sink completions raise interrupt bits 24 to 31 by themselves; here source done sets bit 24 and sink limit sets bit 25 only
// [R4] source and sink words default to 32 bits
// [R5] source and sink widths are separate parameters: 8, 16, 32, 64 or 128
// [R6] user drives write word, address, write flag, strobe, lane mask, dll off
// [R7] command ready shows room; strobe only while ready; read words with valid
// [R8] calibration-done flag tells when sram transfers can be trusted
// [R9] sram commands and read data pass through a buffer adding read latency
// [R10] sram reachable only from user logic, never from the host bus
// [R11] single step: one register word, valid for one cycle; sink keeps last word
// [R12] read words return in command order, one valid strobe per word
module dss_socket #(
  parameter int SRC_W     = `DSS_DEF_WORD_W,  // see [R4] [R5]
  parameter int SNK_W     = `DSS_DEF_WORD_W,  // see [R4] [R5]
  parameter int BUF_DEPTH = `DSS_DEF_BUF_DEPTH,
  parameter int BUF_AW    = `DSS_DEF_BUF_AW,
  parameter int PADDR_W   = `DSS_DEF_PADDR_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [PADDR_W-1:0]          paddr,
  input  wire dss_pkg::dss_word_t          pwdata,
  output var  dss_pkg::dss_word_t          prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  output var  logic                        irq,
  output var  logic [SRC_W-1:0]            data_source,
  output var  logic                        valid_source,
  input  wire logic                        rfd_source,
  input  wire logic [SNK_W-1:0]            data_sink,
  input  wire logic                        valid_sink,
  output var  logic                        rfd_sink,
  input  wire logic [`DSS_SRAM_DATA_W-1:0] wr_word,
  input  wire logic [`DSS_SRAM_ADDR_W-1:0] word_addr,
  input  wire logic                        wr_sel,
  input  wire logic                        cmd_strobe,
  input  wire logic [`DSS_SRAM_LANE_W-1:0] lane_mask,
  input  wire logic                        dll_off,
  output var  logic [`DSS_SRAM_DATA_W-1:0] rd_word,
  output var  logic                        rd_valid,
  output var  logic                        cmd_ready,
  output var  logic                        cal_done,
  output var  logic                        mem_cmd_valid,
  input  wire logic                        mem_cmd_ready,
  output var  logic [`DSS_SRAM_DATA_W-1:0] mem_wr_word,
  output var  logic [`DSS_SRAM_ADDR_W-1:0] mem_word_addr,
  output var  logic                        mem_wr_sel,
  output var  logic [`DSS_SRAM_LANE_W-1:0] mem_lane_mask,
  output var  logic                        mem_dll_off,
  input  wire logic [`DSS_SRAM_DATA_W-1:0] mem_rd_word,
  input  wire logic                        mem_rd_valid,
  input  wire logic                        mem_trained
);
  import dss_pkg::*;

  localparam int IRQ_W = `DSS_IRQ_HI - `DSS_IRQ_LO + 1;

  typedef struct packed {
    logic                        pready;
    dss_word_t                   prdata;
    logic                        pslverr;
    dss_src_state_t              src_state;
    logic                        cont;
    logic                        step_mode;
    logic                        snk_en;
    logic [`DSS_CNT_W-1:0]       src_limit;
    logic [`DSS_CNT_W-1:0]       src_count;
    logic [`DSS_CNT_W-1:0]       snk_limit;
    logic [`DSS_CNT_W-1:0]       snk_count;
    logic [BUF_AW-1:0]           wr_ptr;
    logic                        s1_vld;
    logic [63:0]                 step_word;
    logic [SRC_W-1:0]            data_source;
    logic                        valid_source;
    logic [SNK_W-1:0]            snk_last;
    logic                        rfd_sink;
    logic [IRQ_W-1:0]            irq_stat;
    logic [IRQ_W-1:0]            irq_mask;
    logic                        irq;
    logic                        hold_vld;
    logic [`DSS_SRAM_DATA_W-1:0] hold_word;
    logic [`DSS_SRAM_ADDR_W-1:0] hold_addr;
    logic                        hold_wr;
    logic [`DSS_SRAM_LANE_W-1:0] hold_lane;
    logic                        dll_off;
    logic                        cmd_ready;
    logic                        rd_valid;
    logic [`DSS_SRAM_DATA_W-1:0] rd_word;
    logic                        cal_done;
  } dss_state_t;

  dss_state_t       st;
  dss_state_t       next_st;
  logic             buf_wr;
  logic             src_issue;
  logic             src_last;
  logic [SRC_W-1:0] buf_rd_data;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // the 64-bit step word is repeated so any width from 8 to 128 is filled
  function automatic logic [SRC_W-1:0] fit_src(input logic [63:0] w);
    logic [127:0] r;
    r = {w, w};
    return r[SRC_W-1:0];
  endfunction

  dss_word_ram #(
    .W     (SRC_W),
    .DEPTH (BUF_DEPTH),
    .AW    (BUF_AW)
  ) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (buf_wr),
    .wr_addr (st.wr_ptr),
    .wr_data (fit_src(st.step_word)),
    .rd_en   (src_issue),
    .rd_addr (st.src_count[BUF_AW-1:0]),
    .rd_data (buf_rd_data)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic          wr_acc;
    logic          hi_zero;
    logic [127:0]  snk_ext;
    logic          snk_last_hit;
    wr_acc       = psel && penable && st.pready && pwrite;
    hi_zero      = (paddr[PADDR_W-1:8] == '0);
    snk_ext      = '0;
    snk_ext[SNK_W-1:0] = st.snk_last;
    snk_last_hit = 1'b0;
    next_st      = st;
    buf_wr       = 1'b0;
    src_issue    = (st.src_state == DSS_SRC_RUN) && rfd_source;
    src_last     = 1'b0;

    // apb: zero wait state, answer prepared in the setup cycle
    next_st.pready  = psel && !penable;
    next_st.pslverr = 1'b0;
    if (psel && !penable) begin
      next_st.prdata = '0;
      if (!hi_zero) begin
        next_st.pslverr = 1'b1;
      end else begin
        case (paddr[7:0])
          `DSS_OFF_CTRL: begin
            next_st.prdata[`DSS_CTRL_START]  = (st.src_state != DSS_SRC_IDLE);
            next_st.prdata[`DSS_CTRL_CONT]   = st.cont;
            next_st.prdata[`DSS_CTRL_SNK_EN] = st.snk_en;
            next_st.prdata[`DSS_CTRL_STEP]   = st.step_mode;
          end
          `DSS_OFF_SRC_LIMIT: next_st.prdata[`DSS_CNT_W-1:0] = st.src_limit;
          `DSS_OFF_SNK_LIMIT: next_st.prdata[`DSS_CNT_W-1:0] = st.snk_limit;
          `DSS_OFF_IRQ_STAT:  next_st.prdata[`DSS_IRQ_HI:`DSS_IRQ_LO] = st.irq_stat;
          `DSS_OFF_IRQ_MASK:  next_st.prdata[`DSS_IRQ_HI:`DSS_IRQ_LO] = st.irq_mask;
          `DSS_OFF_SNK_COUNT: next_st.prdata[`DSS_CNT_W-1:0] = st.snk_count;
          `DSS_OFF_SRAM_STAT: begin
            next_st.prdata[`DSS_SRAM_CAL]   = st.cal_done;  // see [R8]
            next_st.prdata[`DSS_SRAM_READY] = st.cmd_ready;
          end
          `DSS_OFF_BUF_DATA:  next_st.prdata = '0;
          `DSS_OFF_STEP_LSW:  next_st.prdata = st.step_word[31:0];
          `DSS_OFF_STEP_MSW:  next_st.prdata = st.step_word[63:32];
          `DSS_OFF_SNK_LSW:   next_st.prdata = snk_ext[31:0];  // see [R11]
          `DSS_OFF_SNK_MSW:   next_st.prdata = snk_ext[63:32];
          default:            next_st.pslverr = 1'b1;
        endcase
      end
    end

    // ****************************************************************
    // data source
    // ****************************************************************
    // two-stage pipe (buffer read, output register) gives the two-cycle tail
    next_st.s1_vld       = src_issue;  // see [R1]
    next_st.valid_source = st.s1_vld;
    if (st.s1_vld) begin
      next_st.data_source = buf_rd_data;
    end
    case (st.src_state)
      DSS_SRC_IDLE: begin
      end
      DSS_SRC_RUN: begin
        if (src_issue) begin
          next_st.src_count = st.src_count + `DSS_CNT_W'(1);
          if (st.src_count + `DSS_CNT_W'(1) >= st.src_limit) begin
            src_last          = 1'b1;
            next_st.src_count = '0;
            if (!st.cont) begin
              next_st.src_state = DSS_SRC_IDLE;
            end
          end
        end
      end
      DSS_SRC_STEP: begin
        next_st.data_source  = fit_src(st.step_word);  // see [R11]
        next_st.valid_source = 1'b1;
        next_st.src_state    = DSS_SRC_IDLE;
      end
      default: next_st.src_state = DSS_SRC_IDLE;
    endcase

    // ****************************************************************
    // data sink
    // ****************************************************************
    if (valid_sink && st.rfd_sink) begin
      next_st.snk_last  = data_sink;  // see [R11]
      next_st.snk_count = st.snk_count + `DSS_CNT_W'(1);
      if (st.snk_limit != '0 && st.snk_count + `DSS_CNT_W'(1) >= st.snk_limit) begin
        snk_last_hit      = 1'b1;
        next_st.snk_count = '0;
      end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    if (wr_acc && hi_zero) begin
      case (paddr[7:0])
        `DSS_OFF_CTRL: begin
          next_st.cont      = pwdata[`DSS_CTRL_CONT];
          next_st.step_mode = pwdata[`DSS_CTRL_STEP];
          next_st.snk_en    = pwdata[`DSS_CTRL_SNK_EN];
          if (pwdata[`DSS_CTRL_START]) begin
            next_st.src_count = '0;
            next_st.src_state = pwdata[`DSS_CTRL_STEP] ? DSS_SRC_STEP : DSS_SRC_RUN;
          end
          if (pwdata[`DSS_CTRL_CLEAR]) begin
            next_st.snk_count = '0;
            next_st.snk_last  = '0;
            next_st.src_state = DSS_SRC_IDLE;
          end
        end
        `DSS_OFF_SRC_LIMIT: next_st.src_limit = pwdata[`DSS_CNT_W-1:0];
        `DSS_OFF_SNK_LIMIT: next_st.snk_limit = pwdata[`DSS_CNT_W-1:0];
        `DSS_OFF_IRQ_STAT:  next_st.irq_stat  = st.irq_stat & ~pwdata[`DSS_IRQ_HI:`DSS_IRQ_LO];
        `DSS_OFF_IRQ_MASK:  next_st.irq_mask  = pwdata[`DSS_IRQ_HI:`DSS_IRQ_LO];
        `DSS_OFF_BUF_DATA: begin
          // the step word registers stage the buffer entry
          buf_wr         = 1'b1;
          next_st.wr_ptr = st.wr_ptr + BUF_AW'(1);
        end
        `DSS_OFF_STEP_LSW:  next_st.step_word[31:0]  = pwdata;
        `DSS_OFF_STEP_MSW:  next_st.step_word[63:32] = pwdata;
        default: begin
        end
      endcase
    end

    // set after the clear so an event in the clearing cycle survives
    if (src_last) begin
      next_st.irq_stat[`DSS_IRQ_SRC_DONE] = 1'b1;  // see [R3]
    end
    if (snk_last_hit) begin
      next_st.irq_stat[`DSS_IRQ_SNK_LIMIT] = 1'b1;  // see [R3]
    end
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    next_st.rfd_sink = next_st.snk_en;

    // ****************************************************************
    // sram user port (no path from the apb side by design)
    // ****************************************************************
    // see [R10]
    if (st.hold_vld && mem_cmd_ready) begin
      next_st.hold_vld = 1'b0;  // see [R9]
    end
    if (cmd_strobe && st.cmd_ready) begin
      next_st.hold_vld  = 1'b1;  // see [R7]
      next_st.hold_word = wr_word;  // see [R6]
      next_st.hold_addr = word_addr;
      next_st.hold_wr   = wr_sel;
      next_st.hold_lane = lane_mask;
    end
    next_st.cmd_ready = !next_st.hold_vld;  // see [R7]
    next_st.dll_off   = dll_off;
    next_st.rd_valid  = mem_rd_valid;  // see [R12]
    if (mem_rd_valid) begin
      next_st.rd_word = mem_rd_word;
    end
    next_st.cal_done = mem_trained;  // see [R8]
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.src_state <= DSS_SRC_IDLE;
      st.snk_en    <= `DSS_SNK_EN_RESET;
      st.rfd_sink  <= `DSS_SNK_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign irq           = st.irq;
  assign data_source   = st.data_source;
  assign valid_source  = st.valid_source;
  assign rfd_sink      = st.rfd_sink;
  assign rd_word       = st.rd_word;
  assign rd_valid      = st.rd_valid;
  assign cmd_ready     = st.cmd_ready;
  assign cal_done      = st.cal_done;
  assign mem_cmd_valid = st.hold_vld;
  assign mem_wr_word   = st.hold_word;
  assign mem_word_addr = st.hold_addr;
  assign mem_wr_sel    = st.hold_wr;
  assign mem_lane_mask = st.hold_lane;
  assign mem_dll_off   = st.dll_off;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_accept_off;
    (!rfd_source && st.src_state != DSS_SRC_STEP)[*3];
  endsequence

  sequence seq_setup;
    psel && !penable;
  endsequence

  a_source_tail_bound: assert property (seq_accept_off |=> !valid_source)  // see [R1]
    else $error("source valid beyond two cycles after accept fell");
  a_step_one_cycle: assert property (
    st.src_state == DSS_SRC_STEP |=> valid_source ##1 !valid_source)  // see [R11]
    else $error("single step valid not exactly one cycle");
  a_src_done_irq: assert property (src_last |=> st.irq_stat[`DSS_IRQ_SRC_DONE])  // see [R3]
    else $error("source completion did not set its interrupt bit");
  a_irq_level: assert property (irq == |(st.irq_stat & st.irq_mask))  // see [R3]
    else $error("interrupt output disagrees with masked status");
  a_width_legal: assert property (
    (SRC_W == 8 || SRC_W == 16 || SRC_W == 32 || SRC_W == 64 || SRC_W == 128) &&
    (SNK_W == 8 || SNK_W == 16 || SNK_W == 32 || SNK_W == 64 || SNK_W == 128))  // see [R5]
    else $error("unsupported source or sink width");
  a_cmd_taken: assert property (
    cmd_strobe && cmd_ready |=> mem_cmd_valid && mem_word_addr == $past(word_addr))  // see [R7]
    else $error("accepted command not presented to memory");
  a_cmd_stall: assert property (mem_cmd_valid && !mem_cmd_ready |=> !cmd_ready)  // see [R9]
    else $error("command ready while the buffer is occupied");
  a_read_order: assert property (
    mem_rd_valid |=> rd_valid && rd_word == $past(mem_rd_word))  // see [R12]
    else $error("read word not returned in order");
  a_cal_follow: assert property (##1 cal_done == $past(mem_trained))  // see [R8]
    else $error("calibration flag does not follow memory");
  a_apb_answer: assert property (seq_setup |=> pready ##1 !pready)
    else $error("apb answer not a single access cycle");
endmodule
`default_nettype wire

// ---- verif/dss_mem_model.sv ----
// memory-side stand-in: stalling command accept, byte-lane storage, in-order read return
`default_nettype none
module dss_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_cmd_valid,
  output var  logic        mem_cmd_ready,
  input  wire logic [63:0] mem_wr_word,
  input  wire logic [17:0] mem_word_addr,
  input  wire logic        mem_wr_sel,
  input  wire logic [7:0]  mem_lane_mask,
  output var  logic [63:0] mem_rd_word,
  output var  logic        mem_rd_valid,
  output var  logic        mem_trained
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] store [logic [17:0]];
  logic [63:0] pend [$];
  logic [63:0] w;
  logic [3:0]  age;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_cmd_ready <= 1'b0;
      mem_rd_valid  <= 1'b0;
      mem_rd_word   <= 64'h0;
      mem_trained   <= 1'b0;
      age           <= 4'h0;
    end else begin
      age           <= age + 4'h1;
      mem_trained   <= mem_trained | (age == 4'h7);
      // stall every other cycle so the holding slot really fills
      mem_cmd_ready <= age[0];
      mem_rd_valid  <= 1'b0;
      // stale word alternates with its complement between returns
      mem_rd_word   <= ~mem_rd_word;
      if (mem_cmd_valid && mem_cmd_ready) begin
        w = store.exists(mem_word_addr) ? store[mem_word_addr] : 64'h0;
        if (mem_wr_sel) begin
          for (int i = 0; i < 8; i++) begin
            if (mem_lane_mask[i]) w[8*i +: 8] = mem_wr_word[8*i +: 8];
          end
          store[mem_word_addr] = w;
        end else begin
          pend.push_back(w);
        end
      end
      // slow, in-order return of reads
      if (pend.size() > 0 && age[1:0] == 2'h3) begin
        mem_rd_word  <= pend.pop_front();
        mem_rd_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_dsp_socket_stream_sram_ports.sv ----
// testbench of the dsp socket: apb registers, stream ports, interrupts, sram port
`include "dss_params.svh"
`default_nettype none
module tb_dsp_socket_stream_sram_ports;
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  dss_word_t   pwdata, prdata, rdv;
  logic [31:0] data_source, data_sink;
  logic        valid_source, rfd_source, valid_sink, rfd_sink;
  logic [63:0] wr_word, rd_word, mem_wr_word, mem_rd_word;
  logic [17:0] word_addr, mem_word_addr;
  logic [7:0]  lane_mask, mem_lane_mask;
  logic        wr_sel, cmd_strobe, dll_off, rd_valid, cmd_ready, cal_done;
  logic        mem_cmd_valid, mem_cmd_ready, mem_wr_sel, mem_dll_off, mem_rd_valid, mem_trained;
  logic [63:0] rq [$];
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;

  dss_socket u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .data_source, .valid_source, .rfd_source, .data_sink,
    .valid_sink, .rfd_sink, .wr_word, .word_addr, .wr_sel, .cmd_strobe, .lane_mask,
    .dll_off, .rd_word, .rd_valid, .cmd_ready, .cal_done, .mem_cmd_valid, .mem_cmd_ready,
    .mem_wr_word, .mem_word_addr, .mem_wr_sel, .mem_lane_mask, .mem_dll_off, .mem_rd_word,
    .mem_rd_valid, .mem_trained);
  dss_mem_model u_mem (.pclk, .presetn, .mem_cmd_valid, .mem_cmd_ready, .mem_wr_word,
    .mem_word_addr, .mem_wr_sel, .mem_lane_mask, .mem_rd_word, .mem_rd_valid, .mem_trained);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  always @(posedge pclk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_word);
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input dss_word_t d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] o, input dss_word_t d);
    apb(1'b1, {4'h0, o}, d);
  endtask
  task automatic rd(input logic [7:0] o, input logic [63:0] e);
    apb(1'b0, {4'h0, o}, 32'h0);
    chk({32'h0, rdv}, e);
  endtask
  task automatic cmd(input logic w, input logic [17:0] a, input logic [63:0] d,
                     input logic [7:0] m);
    @(posedge pclk);
    wr_sel     <= w;
    word_addr  <= a;
    wr_word    <= d;
    lane_mask  <= m;
    cmd_strobe <= 1'b1;
    // strobe held while ready is low must not be taken twice
    do @(posedge pclk); while (cmd_ready !== 1'b1);
    cmd_strobe <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(`DSS_OFF_CTRL, 64'h8);
    chk({63'h0, rfd_sink}, 64'h1);
    rd(`DSS_OFF_IRQ_STAT, 64'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({63'h0, err}, 64'h1);
    apb(1'b1, 12'h040, 32'h1);
    chk({63'h0, err}, 64'h1);
    $display("test reset_map done");
  endtask
  task automatic t_sink();
    wr(`DSS_OFF_SNK_LIMIT, 32'h2);
    for (int i = 1; i < 3; i++) begin
      @(posedge pclk);
      data_sink  <= 32'h1111_0000 + i;
      valid_sink <= 1'b1;
      @(posedge pclk);
      valid_sink <= 1'b0;
    end
    rd(`DSS_OFF_SNK_LSW, 64'h1111_0002);
    rd(`DSS_OFF_SNK_COUNT, 64'h0);
    rd(`DSS_OFF_IRQ_STAT, 64'h0200_0000);
    wr(`DSS_OFF_IRQ_STAT, 32'hff00_0000);
    wr(`DSS_OFF_CTRL, 32'h0);
    @(posedge pclk);
    chk({63'h0, rfd_sink}, 64'h0);
    wr(`DSS_OFF_CTRL, 32'h8);
    $display("test sink done");
  endtask
  task automatic t_step();
    int n = 0;
    wr(`DSS_OFF_STEP_LSW, 32'hcafe_0123);
    wr(`DSS_OFF_CTRL, 32'h19);
    repeat (12) begin
      @(posedge pclk);
      if (valid_source === 1'b1) begin
        n++;
        chk({32'h0, data_source}, 64'hcafe_0123);
      end
    end
    chk(64'(n), 64'h1);
    $display("test step done");
  endtask
  task automatic t_run();
    int n = 0;
    for (int i = 0; i < 4; i++) begin
      // a buffer entry is staged through the step word
      wr(`DSS_OFF_STEP_LSW, 32'ha0 + i);
      wr(`DSS_OFF_BUF_DATA, 32'h0);
    end
    wr(`DSS_OFF_SRC_LIMIT, 32'h4);
    wr(`DSS_OFF_IRQ_STAT, 32'hff00_0000);
    wr(`DSS_OFF_IRQ_MASK, 32'h0100_0000);
    wr(`DSS_OFF_CTRL, 32'h9);
    repeat (20) begin
      @(posedge pclk);
      if (valid_source === 1'b1) begin
        chk({32'h0, data_source}, 64'ha0 + n);
        n++;
      end
    end
    chk(64'(n), 64'h4);
    chk({63'h0, irq}, 64'h1);
    rd(`DSS_OFF_IRQ_STAT, 64'h0100_0000);
    wr(`DSS_OFF_IRQ_STAT, 32'h0100_0000);
    repeat (2) @(posedge pclk);
    chk({63'h0, irq}, 64'h0);
    wr(`DSS_OFF_CTRL, 32'hb);
    do @(posedge pclk); while (valid_source !== 1'b1);
    // user fifo full: accept withdrawn, count from the first edge that sees it low
    rfd_source <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge pclk);
      if (valid_source === 1'b1) n++;
    end
    chk(64'(n <= 2), 64'h1);
    wr(`DSS_OFF_CTRL, 32'hc);
    rd(`DSS_OFF_CTRL, 64'h8);
    $display("test source run done");
  endtask
  task automatic t_sram();
    do @(posedge pclk); while (cal_done !== 1'b1);
    rd(`DSS_OFF_SRAM_STAT, 64'h3);
    dll_off <= 1'b1;
    cmd(1'b1, 18'h5, 64'h0123_4567_89ab_cdef, 8'hff);
    cmd(1'b1, 18'h9, 64'hffee_ddcc_bbaa_9988, 8'h0f);
    chk({63'h0, mem_dll_off}, 64'h1);
    cmd(1'b0, 18'h5, 64'h0, 8'h0);
    cmd(1'b0, 18'h9, 64'h0, 8'h0);
    do @(posedge pclk); while (rq.size() < 2);
    repeat (10) @(posedge pclk);
    chk(64'(rq.size()), 64'h2);
    chk(rq[0], 64'h0123_4567_89ab_cdef);
    chk(rq[1], 64'h0000_0000_bbaa_9988);
    $display("test sram done");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    rfd_source = 1'b1;
    data_sink  = 32'h0;
    valid_sink = 1'b0;
    wr_word    = 64'h0;
    word_addr  = 18'h0;
    wr_sel     = 1'b0;
    cmd_strobe = 1'b0;
    lane_mask  = 8'h0;
    dll_off    = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sink();
    t_step();
    t_run();
    t_sram();
    summarize();
  end
endmodule
`default_nettype wire
